// [ebsc_defs.vh]
`ifndef EBSC_DEFS_VH
`define EBSC_DEFS_VH
`define EBSC_ADDR_W 20
`define EBSC_AD_W 16
`define EBSC_EXT_W 4
`define EBSC_WAIT_W 4
`define EBSC_REG_CFG 2'h0
`define EBSC_REG_PORT 2'h1
`define EBSC_REG_STAT 2'h2
`define EBSC_REG_PIN 2'h3
`define EBSC_CFG_RST 16'h0000
`define EBSC_PORT_RST 16'h0000
`define EBSC_BIT_WRL_SEL 0
`define EBSC_BIT_WRH_SEL 1
`define EBSC_BIT_WR_EN 2
`define EBSC_BIT_BHE_EN 3
`define EBSC_BIT_RDY_EN 4
`define EBSC_BIT_BW16 5
`define EBSC_BIT_BW8 6
`define EBSC_BIT_ADV_SEL 7
`define EBSC_WMAX_LSB 8
`define EBSC_EXT_LSB 12
`define EBSC_PORT_WR 0
`define EBSC_PORT_HI 1
`define EBSC_PORT_RDY 2
`define EBSC_RD_LAT 2
`define EBSC_ST_IDLE 2'h0
`define EBSC_ST_ADDR 2'h1
`define EBSC_ST_DATA 2'h2
`define EBSC_ST_WAIT 2'h3
`endif

// [ebsc_top.v]
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`include "ebsc_defs.vh"
module ebsc_top #(
   parameter WAIT_W = `EBSC_WAIT_W
) (
   input wire i_mclk,
   input wire i_rst_n,
   input wire i_req,
   input wire i_req_wr,
   input wire [`EBSC_ADDR_W-1:0] i_req_addr,
   input wire [1:0] i_req_be,
   input wire [`EBSC_AD_W-1:0] i_req_wdata,
   input wire i_irq_pending_ext,
   input wire [1:0] i_reg_addr,
   input wire [15:0] i_reg_wdata,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire i_ready_pin,
   input wire i_buswidth_pin,
   input wire [`EBSC_AD_W-1:0] i_ad_pin,
   output reg o_busy,
   output reg o_done,
   output reg [`EBSC_AD_W-1:0] o_rdata,
   output reg [15:0] o_reg_rdata,
   output reg o_clock_output,
   output reg o_write_low_strobe_n,
   output reg o_write_low_strobe_oe,
   output reg o_write_high_strobe_n,
   output reg o_write_high_strobe_oe,
   output reg o_rd_n,
   output reg o_address_valid_n,
   output reg o_irq_needs_bus_n,
   output reg [`EBSC_AD_W-1:0] o_ad_out,
   output reg [`EBSC_AD_W-1:0] o_ad_oe,
   output reg [`EBSC_EXT_W-1:0] o_extended_addr_port,
   output reg o_ready_port_oe,
   output reg o_cycle16
);
   reg rst_s1_reg, rst_s2_reg;
   wire rst_n = rst_s2_reg;
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end
   // pins come from outside the clock domain
   reg rdy_s1_reg, rdy_s2_reg, bw_s1_reg, bw_s2_reg;
   reg [`EBSC_AD_W-1:0] ad_s1_reg, ad_s2_reg;
   always @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         rdy_s1_reg <= 1'b1;
         rdy_s2_reg <= 1'b1;
         bw_s1_reg <= 1'b0;
         bw_s2_reg <= 1'b0;
         ad_s1_reg <= {`EBSC_AD_W{1'b0}};
         ad_s2_reg <= {`EBSC_AD_W{1'b0}};
      end else begin
         rdy_s1_reg <= i_ready_pin;
         rdy_s2_reg <= rdy_s1_reg;
         bw_s1_reg <= i_buswidth_pin;
         bw_s2_reg <= bw_s1_reg;
         ad_s1_reg <= i_ad_pin;
         ad_s2_reg <= ad_s1_reg;
      end
   end
   reg [15:0] cfg_reg, port_reg;
   always @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_reg <= `EBSC_CFG_RST;
         port_reg <= `EBSC_PORT_RST;
      end else if (i_reg_wr) begin
         if (i_reg_addr == `EBSC_REG_CFG)
            cfg_reg <= i_reg_wdata;
         if (i_reg_addr == `EBSC_REG_PORT)
            port_reg <= i_reg_wdata;
      end
   end
   wire wrh_sel = cfg_reg[`EBSC_BIT_WRH_SEL];
   wire wrl_sel = cfg_reg[`EBSC_BIT_WRL_SEL];
   wire wr_en = cfg_reg[`EBSC_BIT_WR_EN];
   wire bhe_en = cfg_reg[`EBSC_BIT_BHE_EN];
   wire rdy_en = cfg_reg[`EBSC_BIT_RDY_EN];
   wire bw16 = cfg_reg[`EBSC_BIT_BW16];
   wire bw8 = cfg_reg[`EBSC_BIT_BW8];
   wire adv_sel = cfg_reg[`EBSC_BIT_ADV_SEL];
   wire [WAIT_W-1:0] wait_max = cfg_reg[`EBSC_WMAX_LSB +: WAIT_W];
   wire [`EBSC_EXT_W-1:0] ext_sel = cfg_reg[`EBSC_EXT_LSB +: `EBSC_EXT_W];
   // port latch bits behind the control pins when their bus use is off
   wire port_wr_bit = port_reg[`EBSC_PORT_WR];
   wire port_hi_bit = port_reg[`EBSC_PORT_HI];
   wire port_rdy_bit = port_reg[`EBSC_PORT_RDY];
   // clock output: half the mclk rate, low phase is the sampling point
   reg clk_ph_reg;
   always @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n)
         clk_ph_reg <= 1'b0;
      else
         clk_ph_reg <= ~clk_ph_reg;
   end
   wire fall_edge = clk_ph_reg;
   reg [1:0] st_reg, st_next;
   reg [`EBSC_ADDR_W-1:0] addr_reg;
   reg [1:0] be_reg;
   reg wr_reg, c16_reg;
   reg [`EBSC_AD_W-1:0] wdata_reg;
   reg [WAIT_W-1:0] wcnt_reg;
   // end of cycle travels two stages so the read word meets the pin sync
   reg [`EBSC_RD_LAT-1:0] end_pipe_reg;
   wire end_pend = |end_pipe_reg;
   wire rdy_low = rdy_en & ~rdy_s2_reg;
   // illegal 00 width setting treated as 16-bit
   function width16_f;
      input sel16;
      input sel8;
      input pin;
      begin
         if (sel16 && sel8)
            width16_f = pin;
         else if (sel8)
            width16_f = 1'b0;
         else
            width16_f = 1'b1;
      end
   endfunction
   // waits stop on ready high or at the cap, whichever comes first
   function wait_stop_f;
      input low;
      input [WAIT_W-1:0] cnt;
      input [WAIT_W-1:0] cap;
      begin
         wait_stop_f = !low || (cnt == cap);
      end
   endfunction
   wire dyn16 = width16_f(bw16, bw8, bw_s2_reg);
   always @* begin
      st_next = st_reg;
      case (st_reg)
         `EBSC_ST_IDLE:
            // no new take until the last end has been reported
            if (i_req && fall_edge && !end_pend)
               st_next = `EBSC_ST_ADDR;
         `EBSC_ST_ADDR:
            if (fall_edge)
               st_next = `EBSC_ST_DATA;
         `EBSC_ST_DATA:
            // sample once per period on the falling phase
            if (fall_edge) begin
               if (rdy_low && wait_max != {WAIT_W{1'b0}})
                  st_next = `EBSC_ST_WAIT;
               else
                  st_next = `EBSC_ST_IDLE;
            end
         `EBSC_ST_WAIT:
            if (fall_edge && wait_stop_f(rdy_low, wcnt_reg, wait_max))
               st_next = `EBSC_ST_IDLE;
         default:
            st_next = `EBSC_ST_IDLE;
      endcase
   end
   always @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= `EBSC_ST_IDLE;
         addr_reg <= {`EBSC_ADDR_W{1'b0}};
         be_reg <= 2'h0;
         wr_reg <= 1'b0;
         c16_reg <= 1'b0;
         wdata_reg <= {`EBSC_AD_W{1'b0}};
         wcnt_reg <= {WAIT_W{1'b0}};
      end else begin
         st_reg <= st_next;
         if (st_reg == `EBSC_ST_IDLE && st_next == `EBSC_ST_ADDR) begin
            addr_reg <= i_req_addr;
            be_reg <= i_req_be;
            wr_reg <= i_req_wr;
            wdata_reg <= i_req_wdata;
            c16_reg <= dyn16;
            wcnt_reg <= {WAIT_W{1'b0}};
         end
         if (st_reg == `EBSC_ST_ADDR && fall_edge)
            c16_reg <= dyn16;
         if (fall_edge && (st_next == `EBSC_ST_WAIT))
            wcnt_reg <= wcnt_reg + 1'b1;
      end
   end
   wire in_cyc = (st_reg != `EBSC_ST_IDLE);
   wire data_ph = (st_reg == `EBSC_ST_DATA) || (st_reg == `EBSC_ST_WAIT);
   wire even_wr = wr_reg & (be_reg[0] | ~addr_reg[0]); // low lane written
   wire odd_wr = wr_reg & (c16_reg ? be_reg[1] : addr_reg[0]);
   // 16-bit lane select: a0 for low bank, enable low for high bank
   wire bhe_n = ~(c16_reg & be_reg[1]);
   // low lane address bit: zero whenever the low byte takes part
   function lane_a0_f;
      input low_lane;
      begin
         lane_a0_f = ~low_lane;
      end
   endfunction
   // active-low strobe from a phase and a lane hit
   function strobe_n_f;
      input phase;
      input hit;
      begin
         strobe_n_f = ~(phase & hit);
      end
   endfunction
   // per pin mux between an address bit and its port latch bit
   function [`EBSC_EXT_W-1:0] ext_mux_f;
      input [`EBSC_EXT_W-1:0] sel;
      input [`EBSC_EXT_W-1:0] addr_bits;
      input [`EBSC_EXT_W-1:0] port_bits;
      begin
         ext_mux_f = (sel & addr_bits) | (~sel & port_bits);
      end
   endfunction
   wire a0 = lane_a0_f(be_reg[0]);
   always @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_clock_output <= 1'b0;
         o_write_low_strobe_n <= 1'b1;
         o_write_low_strobe_oe <= 1'b0;
         o_write_high_strobe_n <= 1'b1;
         o_write_high_strobe_oe <= 1'b0;
         o_rd_n <= 1'b1;
         o_address_valid_n <= 1'b1;
         o_irq_needs_bus_n <= 1'b1;
         o_ad_out <= {`EBSC_AD_W{1'b0}};
         o_ad_oe <= {`EBSC_AD_W{1'b0}};
         o_extended_addr_port <= {`EBSC_EXT_W{1'b0}};
         o_ready_port_oe <= 1'b0;
         o_busy <= 1'b0;
         o_cycle16 <= 1'b0;
      end else begin
         o_clock_output <= clk_ph_reg;
         // busy spans the trailing stages so the width stays valid at done
         o_busy <= in_cyc | end_pend;
         o_cycle16 <= c16_reg & (in_cyc | end_pend);
         o_irq_needs_bus_n <= ~i_irq_pending_ext;
         if (wr_en) begin
            if (wrl_sel)
               o_write_low_strobe_n <= strobe_n_f(data_ph, even_wr);
            else
               o_write_low_strobe_n <= strobe_n_f(data_ph, wr_reg);
         end else
            o_write_low_strobe_n <= port_wr_bit;
         o_write_low_strobe_oe <= 1'b1;
         if (bhe_en) begin
            if (wrh_sel)
               o_write_high_strobe_n <= strobe_n_f(data_ph, c16_reg & odd_wr);
            else
               o_write_high_strobe_n <= ~in_cyc | bhe_n;
         end else
            o_write_high_strobe_n <= port_hi_bit;
         o_write_high_strobe_oe <= 1'b1;
         o_ready_port_oe <= ~rdy_en & port_rdy_bit;
         o_rd_n <= ~(data_ph & ~wr_reg);
         // adv falls over the address phase, rises as the cycle ends
         o_address_valid_n <= ~(adv_sel & in_cyc);
         if (in_cyc && !data_ph) begin
            o_ad_out <= {addr_reg[`EBSC_AD_W-1:1], a0};
            o_ad_oe <= {`EBSC_AD_W{1'b1}};
         end else if (data_ph && wr_reg) begin
            o_ad_out <= wdata_reg;
            o_ad_oe <= {`EBSC_AD_W{1'b1}};
         end else if (data_ph) begin
            o_ad_out <= {`EBSC_AD_W{1'b0}};
            o_ad_oe <= {`EBSC_AD_W{1'b0}};
         end else begin
            // open drain: drive only zeros when idle
            o_ad_out <= {`EBSC_AD_W{1'b0}};
            o_ad_oe <= ~port_reg;
         end
         // per pin choice between address and port bit
         o_extended_addr_port <= ext_mux_f(ext_sel, addr_reg[`EBSC_ADDR_W-1:`EBSC_AD_W],
            port_reg[`EBSC_EXT_LSB +: `EBSC_EXT_W]);
      end
   end
   // pins reach logic two flops late, so the read word and the end pulse
   // trail the last data edge by two cycles; costs two cycles per access
   wire cyc_end = in_cyc && (st_next == `EBSC_ST_IDLE);
   always @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         end_pipe_reg <= {`EBSC_RD_LAT{1'b0}};
         o_done <= 1'b0;
         o_rdata <= {`EBSC_AD_W{1'b0}};
      end else begin
         end_pipe_reg <= {end_pipe_reg[`EBSC_RD_LAT-2:0], cyc_end};
         o_done <= end_pipe_reg[`EBSC_RD_LAT-1];
         // wr_reg holds: no take can land while the end is pending
         if (end_pipe_reg[`EBSC_RD_LAT-1] && !wr_reg)
            o_rdata <= ad_s2_reg;
      end
   end
   // register read port: data stands the cycle after the read strobe
   always @(posedge i_mclk or negedge rst_n) begin
      if (!rst_n) begin
         o_reg_rdata <= 16'h0000;
      end else begin
         case (i_reg_addr)
            `EBSC_REG_CFG: o_reg_rdata <= cfg_reg;
            `EBSC_REG_PORT: o_reg_rdata <= port_reg;
            `EBSC_REG_STAT: o_reg_rdata <= {10'h000, wcnt_reg[1:0], st_reg, c16_reg, in_cyc};
            `EBSC_REG_PIN: o_reg_rdata <= ad_s2_reg;
            default: o_reg_rdata <= 16'h0000;
         endcase
      end
   end
endmodule // ebsc_top

// [ebsc_assertions.sv]
`timescale 1ns/1ps
module ebsc_assertions (
   input wire i_mclk,
   input wire i_rst_n,
   input wire i_req_wr,
   input wire [1:0] i_req_be,
   input wire i_irq_pending_ext,
   input wire [1:0] i_reg_addr,
   input wire [15:0] i_reg_wdata,
   input wire i_reg_wr,
   input wire o_busy,
   input wire o_done,
   input wire o_write_low_strobe_n,
   input wire o_write_high_strobe_n,
   input wire o_rd_n,
   input wire o_irq_needs_bus_n,
   input wire [15:0] o_ad_out,
   input wire [15:0] o_ad_oe
);
   reg [15:0] cfg_reg;
   wire [15:0] c = cfg_reg;
   // shadow only valid because config is written while idle
   always @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n)
         cfg_reg <= 16'h0000;
      else if (i_reg_wr && i_reg_addr == 2'h0)
         cfg_reg <= i_reg_wdata;
   end
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_n);
   wr_every_a:
   assert property ($rose(o_busy) && i_req_wr && c[2] && !c[0] |-> ##[1:8]
      !o_write_low_strobe_n) else $error("write strobe missing");
   wrl_even_a:
   assert property (o_busy && i_req_wr && !i_req_be[0] && c[2] && c[0] |->
      o_write_low_strobe_n) else $error("low strobe on odd write");
   wrh_odd_a:
   assert property ($rose(o_busy) && i_req_wr && i_req_be[1] && c[3] && c[1] |-> ##[1:8]
      !o_write_high_strobe_n) else $error("high strobe missing");
   rdy_off_a:
   assert property ($rose(o_busy) && !c[4] |-> ##[4:6] o_done)
      else $error("cycle stretched with ready off");
   wait_cap_a:
   assert property ($rose(o_busy) |-> ##[1:40] o_done) else $error("wait cap broken");
   irq_out_a:
   assert property ($rose(i_irq_pending_ext) |-> ##[1:4] !o_irq_needs_bus_n)
      else $error("bus irq output not low");
   ad_drain_a:
   assert property ((!o_busy)[*3] |-> (o_ad_oe & o_ad_out) == 16'h0000)
      else $error("ad port drives high");
   idle_hi_a:
   assert property ((!o_busy)[*3] |-> o_rd_n && (!c[2] || !$past(c[2]) ||
      o_write_low_strobe_n)) else $error("strobe low while idle");
endmodule // ebsc_assertions
bind ebsc_top ebsc_assertions ebsc_assertions_i (.*);

// [ebsc_mem_model.sv]
`timescale 1ns/1ps
module ebsc_mem_model (
   input wire i_mclk,
   input wire i_adv_n,
   input wire i_rd_n,
   input wire i_wrl_n,
   input wire [15:0] i_ad_out,
   input wire [15:0] i_ad_oe,
   input wire [3:0] i_ext,
   input wire [7:0] i_waits,
   output wire [15:0] o_ad_pin,
   output wire o_ready,
   output reg [19:0] o_addr
);
   reg [15:0] mem [0:63];
   reg adv_q = 1'h1;
   reg [8:0] cnt = 9'h000;
   wire [15:0] drv = i_rd_n ? 16'hFFFF : mem[o_addr[6:1]];
   // released lines take memory data while read strobe is low, else float up through the bus pullups
   assign o_ad_pin = (i_ad_oe & i_ad_out) | (~i_ad_oe & drv);
   // pull ready low as soon as address valid falls, ahead of the sample point
   assign o_ready = (cnt == 9'h000) && !(adv_q && !i_adv_n && i_waits != 8'h00);
   always @(posedge i_mclk) begin
      adv_q <= i_adv_n;
      if (adv_q && !i_adv_n) begin
         o_addr <= {i_ext, i_ad_out};
         cnt <= {i_waits, 1'h0};
      end else if (cnt != 9'h000)
         cnt <= cnt - 9'h001;
      if (!i_wrl_n)
         mem[o_addr[6:1]] <= i_ad_out;
   end
endmodule // ebsc_mem_model

// [tb_top.sv]
`timescale 1ns/1ps
`include "ebsc_defs.vh"
module tb_top;
   reg i_mclk = 1'h0, i_rst_n = 1'h0, i_req = 1'h0, i_req_wr = 1'h0, rd_q = 1'h0;
   reg i_irq_pending_ext = 1'h0, i_reg_wr = 1'h0, i_reg_rd = 1'h0, i_buswidth_pin = 1'h1;
   reg [19:0] i_req_addr = 20'h00000, a;
   reg [1:0] i_req_be = 2'h0, i_reg_addr = 2'h0;
   reg [15:0] i_req_wdata = 16'h0000, i_reg_wdata = 16'h0000, d;
   reg [7:0] waits = 8'h00;
   logic [38:0] e, q[$];
   reg [111:0] cft = {16'hF3EC, 16'hF3DC, 16'hF3FC, 16'hF3FF, 16'hF3FE, 16'hF3FD, 16'hF3FC};
   integer errors = 0, checks_done = 0, cyc = 0, k, n;
   wire i_ready_pin, o_busy, o_done, o_clock_output, o_rd_n, o_address_valid_n, o_cycle16;
   wire o_write_low_strobe_n, o_write_low_strobe_oe, o_write_high_strobe_n;
   wire o_write_high_strobe_oe, o_irq_needs_bus_n, o_ready_port_oe;
   wire [15:0] i_ad_pin, o_rdata, o_reg_rdata, o_ad_out, o_ad_oe;
   wire [3:0] o_extended_addr_port;
   wire [19:0] m_addr;
   ebsc_top ebsc_top_i (.*);
   ebsc_mem_model ebsc_mem_model_i (.i_mclk, .i_adv_n(o_address_valid_n), .i_rd_n(o_rd_n),
      .i_wrl_n(o_write_low_strobe_n), .i_ad_out(o_ad_out), .i_ad_oe(o_ad_oe),
      .i_ext(o_extended_addr_port), .i_waits(waits), .o_ad_pin(i_ad_pin),
      .o_ready(i_ready_pin), .o_addr(m_addr));
   always #50 i_mclk = ~i_mclk;
   task chk(input string s, input [38:0] x, input [38:0] g);
      checks_done = checks_done + 1;
      if (g !== x) begin
         errors = errors + 1;
         $display("MISMATCH %0s exp %0h got %0h", s, x, g);
      end
   endtask
   task results;
      if (errors == 0 && checks_done > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // gap cycle after each access keeps strobes single-driven
   task rw(input w, input [1:0] ad, input [15:0] v);
      i_reg_wr <= w;
      i_reg_rd <= !w;
      i_reg_addr <= ad;
      i_reg_wdata <= v;
      if (!w)
         q.push_back({23'h000000, v});
      @(posedge i_mclk);
      i_reg_wr <= 1'h0;
      i_reg_rd <= 1'h0;
      @(posedge i_mclk);
   endtask
   task bus(input w, input [19:0] ad, input [1:0] be, input c16);
      i_req <= 1'h1;
      i_req_wr <= w;
      i_req_addr <= ad;
      i_req_be <= be;
      i_req_wdata <= d;
      q.push_back({1'h1, w, c16, ad, d});
      @(posedge i_mclk);
      for (n = 0; n < 50 && !o_done; n = n + 1) begin
         if (o_busy)
            i_req <= 1'h0;
         @(posedge i_mclk);
      end
      chk("done", 39'h1, o_done);
   endtask
   always @(posedge i_mclk) begin
      rd_q <= i_reg_rd;
      cyc = cyc + 1;
      if ((rd_q || o_done) && q.size() > 0) begin
         e = q.pop_front();
         if (!e[38])
            chk("reg", e[15:0], o_reg_rdata);
         else begin
            chk("addr", e[35:16], m_addr);
            chk("width", e[36], o_cycle16);
            if (!e[37])
               chk("rdata", e[15:0], o_rdata);
         end
      end
      if (cyc == 20000) begin
         chk("timeout", 39'h0, 39'h1);
         results;
      end
   end
   initial begin
      void'($urandom(60));
      repeat (20) @(posedge i_mclk);
      i_rst_n <= 1'h1;
      repeat (4) @(posedge i_mclk);
      rw(0, `EBSC_REG_CFG, `EBSC_CFG_RST);
      rw(1, `EBSC_REG_PORT, 16'h5006);
      rw(0, `EBSC_REG_PORT, 16'h5006);
      i_irq_pending_ext <= 1'h1;
      repeat (5) @(posedge i_mclk);
      chk("wr_pin", 39'h0, o_write_low_strobe_n);
      chk("hi_pin", 39'h1, o_write_high_strobe_n);
      chk("extended_addr_port", 39'h5, o_extended_addr_port);
      chk("irq", 39'h0, o_irq_needs_bus_n);
      chk("wr_oe", 39'h1, o_write_low_strobe_oe);
      chk("hi_oe", 39'h1, o_write_high_strobe_oe);
      chk("rdy_oe", 39'h1, o_ready_port_oe);
      chk("ad_oe", 39'hAFF9, o_ad_oe);
      i_irq_pending_ext <= 1'h0;
      for (k = 0; k < 7; k = k + 1) begin
         i_buswidth_pin <= (k != 4);
         waits <= (k == 6) ? 8'h09 : 8'($urandom % 5);
         rw(1, `EBSC_REG_CFG, cft[k*16 +: 16]);
         d = 16'($urandom);
         a = 20'($urandom) & 20'hFFFFE;
         if (k == 4 || k == 5)
            bus(1, a, 2'h1, 1'h0);
         else begin
            bus(1, a, 2'h3, 1'h1);
            bus(0, a, 2'h3, 1'h1);
            bus(1, a | 20'h00001, 2'h2, 1'h1);
         end
      end
      results;
   end
endmodule // tb_top
